/* File: drive_cmd_pkg.sv */
// Package with constants and types for the drive command and state words
// Notes on behaviour
// - Bits 1:0 pick one of four presets
// - Bit 2 low brakes by DC, then stops
// - Bit 3 low coasts, output stage off
// - Bit 4 low gives a quick stop
// - Bit 5 low freezes the output frequency
// - While frozen, only coast or brake stop
// - Bit 6 low ramp stops, high permits start
// - Trip reset only on rising bit 7
// - Bit 8 high selects the jog speed
// - Bit 9 selects ramp set 1 or 2
// - Bit 10 low makes the whole word ignored
// - Bit 11 drives relay 01 if configured
// - Bit 12 drives relay 04 if configured
// - Bits 14:13 pick set-up in multi mode
// - Bit 15 reverses when its source allows
// - Status bits 3, 4, 6 report faults
// - Status bit 5 is reserved, reads zero
// - Status bit 8 means speed equals reference
// - Status bit 9 means bus control possible
// - Status bit 11 means start or moving
// - Status bits 15, 14, 13 report limits
// - Link loss forces the whole status to zero
// - Status bit 12 means overtemperature auto-stop
// - Parameter values are whole scaled numbers
package drive_cmd_pkg;
  // Control word bit positions
  localparam int CW_PRESET_LO = 0;
  localparam int CW_PRESET_HI = 1;
  localparam int CW_DC_BRAKE_N = 2;
  localparam int CW_COAST_N = 3;
  localparam int CW_QSTOP_N = 4;
  localparam int CW_HOLD_N = 5;
  localparam int CW_START = 6;
  localparam int CW_RESET = 7;
  localparam int CW_JOG = 8;
  localparam int CW_RAMP2 = 9;
  localparam int CW_VALID = 10;
  localparam int CW_RELAY1 = 11;
  localparam int CW_RELAY4 = 12;
  localparam int CW_SETUP_LO = 13;
  localparam int CW_SETUP_HI = 14;
  localparam int CW_REVERSE = 15;
  // Status word bit positions
  localparam int SW_CTRL_READY = 0;
  localparam int SW_DRIVE_READY = 1;
  localparam int SW_ENABLE = 2;
  localparam int SW_TRIP = 3;
  localparam int SW_ERROR = 4;
  localparam int SW_RESERVED = 5;
  localparam int SW_TRIP_LOCK = 6;
  localparam int SW_WARNING = 7;
  localparam int SW_AT_REF = 8;
  localparam int SW_BUS_CTRL = 9;
  localparam int SW_FREQ_OK = 10;
  localparam int SW_RUNNING = 11;
  localparam int SW_AUTOSTART = 12;
  localparam int SW_VOLTAGE = 13;
  localparam int SW_TORQUE = 14;
  localparam int SW_TIMER = 15;
  // Reset values
  localparam logic [15:0] CMD_WORD_RESET = 16'h0000;
  localparam logic [15:0] STATE_WORD_RESET = 16'h0000;
  // Reverse source selections
  localparam logic [1:0] REV_DIGITAL = 2'h0;
  localparam logic [1:0] REV_SERIAL = 2'h1;
  localparam logic [1:0] REV_LOGIC_OR = 2'h2;
  localparam logic [1:0] REV_LOGIC_AND = 2'h3;

  // Stop mode priority encoding, one-hot
  typedef enum logic [4:0] {
    STOP_NONE = 5'h01,
    STOP_COAST = 5'h02,
    STOP_DC_BRAKE = 5'h04,
    STOP_QUICK = 5'h08,
    STOP_RAMP = 5'h10
  } stop_mode_e;

  // Decoded command bundle
  typedef struct packed {
    logic [1:0] preset_sel;
    logic dc_brake;
    logic coast;
    logic quick_stop;
    logic hold_freq;
    logic ramp_stop;
    logic start_ok;
    logic trip_reset;
    logic jog;
    logic ramp2_sel;
    logic relay1_on;
    logic relay4_on;
    logic [1:0] setup_sel;
    logic reverse;
    stop_mode_e stop_mode;
  } drive_cmd_s;

  // Drive flags that feed the status word
  typedef struct packed {
    logic ctrl_ready;
    logic drive_ready;
    logic enable;
    logic trip;
    logic error_no_trip;
    logic trip_lock;
    logic warning;
    logic at_reference;
    logic local_stop;
    logic local_ref;
    logic freq_in_limit;
    logic start_signal;
    logic freq_nonzero;
    logic overtemp_stop;
    logic dc_volt_fault;
    logic current_limit;
    logic motor_timer_over;
    logic inv_timer_over;
  } drive_flags_s;

  // Configuration bundle
  typedef struct packed {
    logic relay1_follows;
    logic relay4_follows;
    logic multi_setup;
    logic [1:0] reverse_src;
  } drive_cfg_s;

  // Whole module state
  typedef struct packed {
    logic [15:0] cmd_word;
    logic reset_seen;
    drive_cmd_s cmd;
    logic [15:0] state_word;
  } ctl_state_s;
endpackage

/* File: drive_control_status_word.sv */
// Control word decoder and status word builder for the drive
`timescale 1ns/100ps
module drive_control_status_word
  import drive_cmd_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic [15:0] cmd_word_i,      // Received command word
  input wire logic cmd_word_strobe_i,      // One-cycle pulse: new word received
  input wire drive_cfg_s cfg_i,            // Drive configuration
  input wire drive_flags_s flags_i,        // Internal drive flags
  input wire logic bus_link_ok_i,          // Bus option link healthy
  input wire logic dig_stop_i,             // Digital input DC brake/coast/reset-coast
  output drive_cmd_s cmd_o,                // Decoded commands
  output logic [15:0] drive_state_word_o   // Status word to master
);

  ////////////////////////////////////////////////////////////////////////
  // State
  ctl_state_s state_reg;   // Registered state
  ctl_state_s state_next;  // Next state

  // Decode a command word into command bundle
  function automatic drive_cmd_s decode(input logic [15:0] w, input drive_cfg_s c,
                                        input logic dstop, input logic prev_rst);
    drive_cmd_s d;
    logic rev_ok;
    d = '0;
    rev_ok = (c.reverse_src == REV_SERIAL) || (c.reverse_src == REV_LOGIC_OR) ||
             (c.reverse_src == REV_LOGIC_AND);
    d.preset_sel = {w[CW_PRESET_HI], w[CW_PRESET_LO]};
    d.dc_brake = ~w[CW_DC_BRAKE_N];
    d.coast = ~w[CW_COAST_N];
    d.hold_freq = ~w[CW_HOLD_N];
    // Frozen output only honours coast, DC brake or digital stop
    d.quick_stop = ~w[CW_QSTOP_N] & w[CW_HOLD_N];
    d.ramp_stop = ~w[CW_START] & w[CW_HOLD_N];
    d.start_ok = w[CW_START] & w[CW_COAST_N] & w[CW_QSTOP_N] & w[CW_DC_BRAKE_N] & ~dstop;
    d.trip_reset = w[CW_RESET] & ~prev_rst;
    d.jog = w[CW_JOG];
    d.ramp2_sel = w[CW_RAMP2];
    d.relay1_on = w[CW_RELAY1] & c.relay1_follows;
    d.relay4_on = w[CW_RELAY4] & c.relay4_follows;
    d.setup_sel = c.multi_setup ? {w[CW_SETUP_HI], w[CW_SETUP_LO]} : 2'h0;
    d.reverse = w[CW_REVERSE] & rev_ok;
    // Stop priority: coast, then DC brake, then quick, then ramp
    if (d.coast || dstop) begin
      d.stop_mode = STOP_COAST;
    end else if (d.dc_brake) begin
      d.stop_mode = STOP_DC_BRAKE;
    end else if (d.quick_stop) begin
      d.stop_mode = STOP_QUICK;
    end else if (d.ramp_stop) begin
      d.stop_mode = STOP_RAMP;
    end else begin
      d.stop_mode = STOP_NONE;
    end
    return d;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    logic [15:0] sw;
    sw = '0;
    state_next = state_reg;
    // Trip reset is a one-cycle pulse
    state_next.cmd.trip_reset = 1'b0;
    // Take a new valid word only
    if (cmd_word_strobe_i && cmd_word_i[CW_VALID]) begin
      state_next.cmd_word = cmd_word_i;
      state_next.cmd = decode(cmd_word_i, cfg_i, dig_stop_i, state_reg.reset_seen);
      state_next.reset_seen = cmd_word_i[CW_RESET];
    end else begin
      // Keep config and digital stop live on the held word
      state_next.cmd = decode(state_reg.cmd_word, cfg_i, dig_stop_i, 1'b1);
    end
    // Status word from current flags
    sw[SW_CTRL_READY] = flags_i.ctrl_ready;
    sw[SW_DRIVE_READY] = flags_i.drive_ready;
    sw[SW_ENABLE] = flags_i.enable;
    sw[SW_TRIP] = flags_i.trip;
    sw[SW_ERROR] = flags_i.error_no_trip;
    sw[SW_RESERVED] = 1'b0;
    sw[SW_TRIP_LOCK] = flags_i.trip_lock;
    sw[SW_WARNING] = flags_i.warning;
    sw[SW_AT_REF] = flags_i.at_reference;
    sw[SW_BUS_CTRL] = ~(flags_i.local_stop | flags_i.local_ref);
    sw[SW_FREQ_OK] = flags_i.freq_in_limit;
    sw[SW_RUNNING] = flags_i.start_signal | flags_i.freq_nonzero;
    sw[SW_AUTOSTART] = flags_i.overtemp_stop;
    sw[SW_VOLTAGE] = flags_i.dc_volt_fault;
    sw[SW_TORQUE] = flags_i.current_limit;
    sw[SW_TIMER] = flags_i.motor_timer_over | flags_i.inv_timer_over;
    // Lost link blanks everything
    state_next.state_word = bus_link_ok_i ? sw : 16'h0000;
  end

  ////////////////////////////////////////////////////////////////////////
  // State register; reset word decodes as coast with no start
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      state_reg.cmd_word <= CMD_WORD_RESET;
      state_reg.reset_seen <= 1'b0;
      state_reg.cmd <= '{preset_sel: 2'h0, dc_brake: 1'b1, coast: 1'b1, quick_stop: 1'b1,
                         hold_freq: 1'b1, ramp_stop: 1'b0, start_ok: 1'b0, trip_reset: 1'b0,
                         jog: 1'b0, ramp2_sel: 1'b0, relay1_on: 1'b0, relay4_on: 1'b0,
                         setup_sel: 2'h0, reverse: 1'b0, stop_mode: STOP_COAST};
      state_reg.state_word <= STATE_WORD_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs straight from flops
  assign cmd_o = state_reg.cmd;
  assign drive_state_word_o = state_reg.state_word;
endmodule

/* File: bus_master_model.sv */
// Bus master model that hands command words to the drive
`timescale 1ns/100ps
module bus_master_model (
  output logic [15:0] cmd_word_o, // Word on the bus
  output logic strobe_o           // One pulse per received word
);
  // Idle bus until the first word
  initial begin
    cmd_word_o = 16'h0000;
    strobe_o = 1'b0;
  end
  // Present one word, called off the sampling edge; bit 10 low marks a word that must not act
  task automatic send(input logic [15:0] w, input logic s);
    cmd_word_o = w;
    strobe_o = s;
  endtask
endmodule

/* File: drive_control_status_word_assertions.sv */
// Checker for the drive command and state words
`timescale 1ns/100ps
module drive_word_checker
  import drive_cmd_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic [15:0] cmd_word_i,
  input wire logic cmd_word_strobe_i,
  input wire drive_cfg_s cfg_i,
  input wire drive_flags_s flags_i,
  input wire logic bus_link_ok_i,
  input wire logic dig_stop_i,
  input wire drive_cmd_s cmd_o,
  input wire logic [15:0] drive_state_word_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  // Word accepted this edge
  wire logic take = cmd_word_strobe_i & cmd_word_i[CW_VALID];
  chk_link_lost_zero: assert property (!bus_link_ok_i |=> drive_state_word_o == 16'h0000)
    else $error("state word not cleared");
  chk_reserved_low: assert property (drive_state_word_o[SW_RESERVED] == 1'b0)
    else $error("reserved state bit set");
  chk_bus_ctrl: assert property (bus_link_ok_i |=>
    drive_state_word_o[SW_BUS_CTRL] == !$past(flags_i.local_stop | flags_i.local_ref)) else $error("bus control bit");
  chk_running_bit: assert property (bus_link_ok_i |=>
    drive_state_word_o[SW_RUNNING] == $past(flags_i.start_signal | flags_i.freq_nonzero)) else $error("running bit");
  chk_reset_cause: assert property (cmd_o.trip_reset |-> $past(take) && $past(cmd_word_i[CW_RESET]))
    else $error("trip reset without rising bit");
  chk_reset_pulse: assert property (cmd_o.trip_reset |=> !cmd_o.trip_reset)
    else $error("trip reset too long");
  chk_word_ignored: assert property (cmd_word_strobe_i && !cmd_word_i[CW_VALID] |=>
    $stable(cmd_o.preset_sel) && $stable(cmd_o.jog)) else $error("invalid word acted");
  chk_preset_latch: assert property (take |=> cmd_o.preset_sel == $past(cmd_word_i[1:0]))
    else $error("preset not latched");
  chk_dig_coast: assert property (dig_stop_i |=> cmd_o.stop_mode == STOP_COAST && !cmd_o.start_ok)
    else $error("digital stop ignored");
  cover property (take ##1 cmd_o.trip_reset);
  cover property (!bus_link_ok_i);
  cover property (dig_stop_i ##1 take);
endmodule
bind drive_control_status_word drive_word_checker chk (.clock_i, .rst_b_i, .cmd_word_i, .cmd_word_strobe_i,
  .cfg_i, .flags_i, .bus_link_ok_i, .dig_stop_i, .cmd_o, .drive_state_word_o);

/* File: tb_drive_control_status_word.sv */
// Random and corner-case bench for the drive command and state words
`timescale 1ns/100ps
module tb_drive_control_status_word;
  import drive_cmd_pkg::*;
  logic clock_i = 1'b0, rst_b_i = 1'b0, link = 1'b1, dig = 1'b0, pulse = 1'b0, armed = 1'b0;
  drive_cfg_s cfg = '0;
  drive_flags_s flg = '0;
  wire logic [15:0] word, sw;
  wire logic stb;
  wire drive_cmd_s cmd;
  logic [15:0] last = 16'h0000; // Last accepted word
  int fails = 0, checks_done = 0, cyc = 0;
  localparam logic [15:0] CORNER [6] = '{16'h0480, 16'h0480, 16'h0400, 16'h0480, 16'h0080, 16'h0400};
  always #50 clock_i = ~clock_i;
  bus_master_model master (.cmd_word_o(word), .strobe_o(stb));
  drive_control_status_word uut (.clock_i(clock_i), .rst_b_i(rst_b_i), .cmd_word_i(word), .cmd_word_strobe_i(stb),
    .cfg_i(cfg), .flags_i(flg), .bus_link_ok_i(link), .dig_stop_i(dig), .cmd_o(cmd), .drive_state_word_o(sw));
  ////////////////////////////////////////////////////////////////////////
  // Expected state word from the flags
  function automatic logic [15:0] exp_sw(drive_flags_s f, logic ok);
    if (!ok) return 16'h0000;
    return {f.motor_timer_over | f.inv_timer_over, f.current_limit, f.dc_volt_fault, f.overtemp_stop,
      f.start_signal | f.freq_nonzero, f.freq_in_limit, !(f.local_stop | f.local_ref), f.at_reference,
      f.warning, f.trip_lock, 1'b0, f.error_no_trip, f.trip, f.enable, f.drive_ready, f.ctrl_ready};
  endfunction
  // Expected decoded command
  function automatic drive_cmd_s exp_cmd(logic [15:0] w, drive_cfg_s c, logic d, logic p);
    stop_mode_e m;
    m = (!w[3] || d) ? STOP_COAST : !w[2] ? STOP_DC_BRAKE : (!w[4] && w[5]) ? STOP_QUICK :
      (!w[6] && w[5]) ? STOP_RAMP : STOP_NONE;
    return drive_cmd_s'{w[1:0], !w[2], !w[3], !w[4] && w[5], !w[5], !w[6] && w[5],
      w[6] && w[3] && w[4] && w[2] && !d, p, w[8], w[9], w[11] && c.relay1_follows,
      w[12] && c.relay4_follows, c.multi_setup ? w[14:13] : 2'h0,
      w[15] && c.reverse_src != REV_DIGITAL, m};
  endfunction
  ////////////////////////////////////////////////////////////////////////
  // Count and report one comparison
  task automatic chk(input logic bad, input string msg);
    checks_done++;
    if (bad) begin
      fails++;
      $display("MISMATCH t=%0t %s", $time, msg);
    end
  endtask
  // One cycle: drive at the falling edge, compare at the next
  task automatic step(input logic [15:0] w, input logic s);
    drive_flags_s f;
    drive_cfg_s c;
    logic l, d, take;
    f = 18'($urandom);
    c = 5'($urandom);
    l = ($urandom % 8) != 0;
    d = ($urandom % 8) == 0;
    take = s & w[10];
    master.send(w, s);
    flg = f;
    cfg = c;
    link = l;
    dig = d;
    @(negedge clock_i);
    pulse = take & w[7] & !last[7];
    if (take) begin
      last = w;
      armed = 1'b1;
    end
    chk(sw !== exp_sw(f, l), "state word");
    if (armed) chk(cmd !== exp_cmd(last, c, d, pulse), "command decode");
  endtask
  // Verdict and end of run
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Main sequence: corner words, then random traffic
  initial begin
    logic [15:0] w;
    void'($urandom(32'h3aaafa2a));
    repeat (2) @(negedge clock_i);
    rst_b_i = 1'b1;
    foreach (CORNER[i]) step(CORNER[i], 1'b1);
    repeat (1500) begin
      w = 16'($urandom) | ((($urandom % 4) != 0) ? 16'h0400 : 16'h0000);
      step(w, 1'($urandom));
    end
    results();
  end
  // Hang guard
  always @(posedge clock_i) begin
    cyc++;
    if (cyc > 4000) begin
      fails++;
      results();
    end
  end
endmodule
